// file: rtl/sbcp_dev.sv
// Device end of the byte configuration port with its byte FIFO
`timescale 1ns/1ns
`include "sbcp_defines.svh"

// ============================================================
// Functional notes
// - link clock input times every bus load
// - external clock steps the configuration logic too; here the loader runs on mclk_in and only samples the link clock
// - one byte taken per rising clock edge
// - host no-handshake below 50 MHz, never 66
// - above that rate host watches busy
// - busy high: host repeats the byte
// - first byte when ready, selected, writing
// - port ignored until init ready rises
// - write select released early aborts load
// - after abort host pulses program, reloads
// - host may hold select high between bytes
// - deselected device ignores all clock edges
// - read direction on selected edge aborts
// - host may toggle direction while clock low
// - write select low writes, high reads
// - busy gates sampling; undriven when deselected
// - data line zero is byte MSB

// ============================================================
// Byte FIFO, flip-flop storage addressed by index
module sbcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    // Fill side
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    // Drain side
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
    wire push = wr_valid_in & wr_ready_out;
    wire pop = rd_valid_out & rd_ready_in;

    // Honest full and empty from the occupancy count
    assign wr_ready_out = (count != (AW+1)'(DEPTH));
    assign rd_valid_out = (count != '0);
    assign rd_data_out = mem[rd_idx];

    // Storage write
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem[wr_idx] <= wr_data_in;
    end

    // Pointers and count
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || flush_in)
        begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            if (pop)
                rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ============================================================
// Device loader with pin synchronisers and byte buffer
module sbcp_dev
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Link to the host
    sbcp_if.dev link,
    // Configuration byte stream out
    output logic [7:0] cfg_byte_out,
    output logic cfg_valid_out,
    input wire logic cfg_ready_in,
    // Status
    output logic done_out,
    output logic abort_out
);
    // ============================================================
    // Pin synchronisers
    logic [1:0] clk_sync;
    logic [1:0] sel_sync;
    logic [1:0] ws_sync;
    logic [1:0] prog_sync;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic clk_last;

    // Two flops per pin before any logic reads it
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            clk_sync <= 2'h0;
            sel_sync <= 2'h3;
            ws_sync <= 2'h3;
            prog_sync <= 2'h3;
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
            clk_last <= 1'b0;
        end
        else
        begin
            clk_sync <= {clk_sync[0], link.config_clock};
            sel_sync <= {sel_sync[0], link.select_n};
            ws_sync <= {ws_sync[0], link.write_select_n};
            prog_sync <= {prog_sync[0], link.program_n};
            data_s1 <= link.data;
            data_s2 <= data_s1;
            clk_last <= clk_sync[1];
        end
    end

    // ============================================================
    // Edge and qualifier decode
    wire clk_rise = clk_sync[1] & ~clk_last;
    wire clk_fall = ~clk_sync[1] & clk_last;
    wire selected = ~sel_sync[1];
    wire writing = ~ws_sync[1];
    wire prog_low = ~prog_sync[1];
    logic [7:0] byte_in;

    // Line zero is the most significant bit of the byte
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_order
            assign byte_in[7 - gi] = data_s2[gi];
        end
    endgenerate

    // ============================================================
    // Loader state
    sbcp_pkg::sbcp_dev_state_e state;
    sbcp_pkg::sbcp_dev_state_e next_state;
    logic [`SBCP_TIMER_W-1:0] init_timer;
    logic [`SBCP_STREAM_CNT_W-1:0] byte_count;
    logic busy;
    logic fifo_ready;

    wire ready = (state == sbcp_pkg::SBCP_DEV_READY);
    wire edge_sel = ready & clk_rise & selected;
    wire bad_dir = edge_sel & ~writing;
    wire take = edge_sel & writing & ~busy;
    wire last_byte = (byte_count == `SBCP_STREAM_CNT_W'(`SBCP_STREAM_BYTES - 1));
    wire init_end = (init_timer == `SBCP_TIMER_W'(`SBCP_INIT_CYCLES - 1));

    // Next state selection
    always_comb
    begin
        next_state = state;
        unique case (state)
            sbcp_pkg::SBCP_DEV_INIT:
                if (init_end)
                    next_state = sbcp_pkg::SBCP_DEV_READY;
            sbcp_pkg::SBCP_DEV_READY:
                if (bad_dir)
                    next_state = sbcp_pkg::SBCP_DEV_ABORT;
                else if (take && last_byte)
                    next_state = sbcp_pkg::SBCP_DEV_DONE;
            sbcp_pkg::SBCP_DEV_DONE:
                next_state = state;
            sbcp_pkg::SBCP_DEV_ABORT:
                next_state = state;
        endcase
        if (prog_low)
            next_state = sbcp_pkg::SBCP_DEV_INIT;
    end

    // State, init timer and stream counter
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state <= sbcp_pkg::SBCP_DEV_INIT;
            init_timer <= '0;
            byte_count <= '0;
        end
        else
        begin
            state <= next_state;
            if (prog_low || state != sbcp_pkg::SBCP_DEV_INIT)
                init_timer <= '0;
            else
                init_timer <= init_timer + 1'b1;
            if (prog_low)
                byte_count <= '0;
            else if (take)
                byte_count <= byte_count + 1'b1;
        end
    end

    // ============================================================
    // Busy: changes only after a falling link edge, so it is stable
    // through the following rising edge on both ends
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            busy <= 1'b0;
        else if (clk_fall)
            busy <= ~fifo_ready;
    end

    // Pin drivers and status flags
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            link.init_ready_n <= 1'b0;
            link.busy <= 1'b0;
            link.busy_oe <= 1'b0;
            done_out <= 1'b0;
            abort_out <= 1'b0;
        end
        else
        begin
            link.init_ready_n <= (next_state != sbcp_pkg::SBCP_DEV_INIT);
            link.busy <= busy;
            link.busy_oe <= selected;
            done_out <= (next_state == sbcp_pkg::SBCP_DEV_DONE);
            abort_out <= (next_state == sbcp_pkg::SBCP_DEV_ABORT);
        end
    end

    // ============================================================
    // Byte buffer between the link and the configuration logic
    sbcp_fifo #(
        .WIDTH(`SBCP_BYTE_W),
        .DEPTH(`SBCP_FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .flush_in(prog_low),
        .wr_data_in(byte_in),
        .wr_valid_in(take),
        .wr_ready_out(fifo_ready),
        .rd_data_out(cfg_byte_out),
        .rd_valid_out(cfg_valid_out),
        .rd_ready_in(cfg_ready_in)
    );
endmodule

// file: common/sbcp_defines.svh
// Constants for the slave byte configuration write port
`ifndef SBCP_DEFINES_SVH
`define SBCP_DEFINES_SVH

// ============================================================
// System clock
`define SBCP_CLK_NS 40
`define SBCP_CLK_MHZ 25

// ============================================================
// Link rates in MHz
`define SBCP_NO_HANDSHAKE_CLOCK_RATE_MHZ 50
`define SBCP_MAX_BYTE_CLOCK_RATE_MHZ 66

// ============================================================
// Host link clock: half period in system cycles (25 MHz / 16)
`define SBCP_HALF_PERIOD_NS 320
`define SBCP_HALF_CYCLES ((`SBCP_HALF_PERIOD_NS + `SBCP_CLK_NS - 1) / `SBCP_CLK_NS)
`define SBCP_HALF_CNT_W 4

// ============================================================
// Device initialisation and program pulse timing
`define SBCP_INIT_NS 640
`define SBCP_INIT_CYCLES ((`SBCP_INIT_NS + `SBCP_CLK_NS - 1) / `SBCP_CLK_NS)
`define SBCP_PROG_NS 400
`define SBCP_PROG_CYCLES ((`SBCP_PROG_NS + `SBCP_CLK_NS - 1) / `SBCP_CLK_NS)
`define SBCP_TIMER_W 8

// ============================================================
// Stream and buffer geometry
`define SBCP_STREAM_BYTES 64
`define SBCP_STREAM_CNT_W 16
`define SBCP_BYTE_W 8
`define SBCP_FIFO_DEPTH 8

`endif

// file: common/sbcp_pkg.sv
// Types shared by both ends of the byte configuration port
package sbcp_pkg;

    // ============================================================
    // Device loader states
    typedef enum logic [1:0]
    {
        SBCP_DEV_INIT  = 2'b00,
        SBCP_DEV_READY = 2'b01,
        SBCP_DEV_DONE  = 2'b10,
        SBCP_DEV_ABORT = 2'b11
    } sbcp_dev_state_e;

    // ============================================================
    // Host sequencer states
    typedef enum logic [1:0]
    {
        SBCP_HOST_IDLE = 2'b00,
        SBCP_HOST_PROG = 2'b01,
        SBCP_HOST_WAIT = 2'b10,
        SBCP_HOST_LOAD = 2'b11
    } sbcp_host_state_e;

endpackage

// file: common/sbcp_if.sv
// Link wires between the configuration host and the device
`timescale 1ns/1ns
interface sbcp_if;
    logic config_clock;
    logic select_n;
    logic write_select_n;
    logic [7:0] data;
    logic program_n;
    logic init_ready_n;
    logic busy;
    logic busy_oe;
    logic busy_line;

    // Busy wire reads low while not driven (weak pull-down)
    assign busy_line = busy_oe & busy;

    modport dev
    (
        input config_clock, select_n, write_select_n, data, program_n, busy_line,
        output init_ready_n, busy, busy_oe
    );

    modport host
    (
        output config_clock, select_n, write_select_n, data, program_n,
        input init_ready_n, busy_line
    );
endinterface

// file: rtl/sbcp_host.sv
// Host end that drives the link clock and loads the byte stream
`timescale 1ns/1ns
`include "sbcp_defines.svh"
module sbcp_host
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Link to the device
    sbcp_if.host link,
    // Command and byte source
    input wire logic start_in,
    input wire logic [7:0] byte_in,
    input wire logic byte_valid_in,
    output logic byte_ready_out,
    // Status
    output logic loading_out
);
    // ============================================================
    // Pin synchronisers for busy and init ready
    logic [1:0] busy_sync;
    logic [1:0] init_sync;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            busy_sync <= 2'h0;
            init_sync <= 2'h0;
        end
        else
        begin
            busy_sync <= {busy_sync[0], link.busy_line};
            init_sync <= {init_sync[0], link.init_ready_n};
        end
    end

    // ============================================================
    // Link clock divider, well under the no-handshake rate
    logic [`SBCP_HALF_CNT_W-1:0] half_cnt;
    logic clk_level;
    wire half_end = (half_cnt == `SBCP_HALF_CNT_W'(`SBCP_HALF_CYCLES - 1));
    wire to_rise = half_end & ~clk_level;
    wire to_fall = half_end & clk_level;

    // Sequencer state
    sbcp_pkg::sbcp_host_state_e state;
    logic [`SBCP_TIMER_W-1:0] prog_timer;
    logic have;
    wire prog_end = (prog_timer == `SBCP_TIMER_W'(`SBCP_PROG_CYCLES - 1));
    wire load = (state == sbcp_pkg::SBCP_HOST_LOAD);
    wire grab = byte_ready_out & byte_valid_in;
    wire taken = load & to_rise & have & ~busy_sync[1];

    // Divider and sequencer
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            half_cnt <= '0;
            clk_level <= 1'b0;
            state <= sbcp_pkg::SBCP_HOST_IDLE;
            prog_timer <= '0;
        end
        else
        begin
            half_cnt <= half_end ? '0 : half_cnt + 1'b1;
            if (half_end)
                clk_level <= ~clk_level;
            prog_timer <= (state == sbcp_pkg::SBCP_HOST_PROG) ? prog_timer + 1'b1 : '0;
            unique case (state)
                sbcp_pkg::SBCP_HOST_IDLE:
                    if (start_in)
                        state <= sbcp_pkg::SBCP_HOST_PROG;
                sbcp_pkg::SBCP_HOST_PROG:
                    if (prog_end)
                        state <= sbcp_pkg::SBCP_HOST_WAIT;
                sbcp_pkg::SBCP_HOST_WAIT:
                    if (init_sync[1])
                        state <= sbcp_pkg::SBCP_HOST_LOAD;
                sbcp_pkg::SBCP_HOST_LOAD:
                    if (start_in)
                        state <= sbcp_pkg::SBCP_HOST_PROG;
            endcase
        end
    end

    // Byte holding: refresh only on falling halves, repeat while busy
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            have <= 1'b0;
            byte_ready_out <= 1'b0;
        end
        else
        begin
            byte_ready_out <= load & to_fall & ~have & ~start_in;
            if (!load)
                have <= 1'b0;
            else if (grab)
                have <= 1'b1;
            else if (taken)
                have <= 1'b0;
        end
    end

    // ============================================================
    // Pin drivers
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            link.config_clock <= 1'b0;
            link.select_n <= 1'b1;
            link.write_select_n <= 1'b1;
            link.data <= 8'h00;
            link.program_n <= 1'b1;
            loading_out <= 1'b0;
        end
        else
        begin
            link.config_clock <= clk_level ^ half_end;
            link.program_n <= ~(state == sbcp_pkg::SBCP_HOST_PROG);
            link.write_select_n <= ~load;
            if (grab)
                link.select_n <= 1'b0;
            else if (!load || (to_fall && !have))
                link.select_n <= 1'b1;
            if (grab)
                link.data <= {byte_in[0], byte_in[1], byte_in[2], byte_in[3],
                              byte_in[4], byte_in[5], byte_in[6], byte_in[7]};
            loading_out <= load;
        end
    end
endmodule

// file: testbench/sbcp_chk.sv
// Link protocol checker for the byte configuration port
`timescale 1ns/1ns
module sbcp_chk
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Link wires
    input wire logic config_clock,
    input wire logic select_n,
    input wire logic write_select_n,
    input wire logic [7:0] data,
    input wire logic program_n,
    input wire logic init_ready_n,
    input wire logic busy,
    input wire logic busy_oe,
    input wire logic busy_line
);
    // ============================================================
    // Assertions on the host to device link
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_busy_release;
        select_n [*6] |-> !busy_oe;
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("busy driven while deselected");

    property p_sel_edge;
        $changed(select_n) |-> !config_clock;
    endproperty
    a_sel_edge: assert property (p_sel_edge) else $error("select moved with clock high");

    property p_write_held;
        !select_n |-> !write_select_n;
    endproperty
    a_write_held: assert property (p_write_held) else $error("write select released");

    property p_repeat;
        $rose(config_clock) && !select_n && busy_line |-> ##10 $stable(data) [*6];
    endproperty
    a_repeat: assert property (p_repeat) else $error("refused byte not repeated");

    property p_clock_high;
        $rose(config_clock) |-> config_clock [*8] ##1 !config_clock;
    endproperty
    a_clock_high: assert property (p_clock_high) else $error("link clock high time wrong");

    property p_busy_steady;
        $rose(config_clock) |-> $stable(busy_line) [*6];
    endproperty
    a_busy_steady: assert property (p_busy_steady) else $error("busy moved at a take");

    property p_busy_after_fall;
        $changed(busy) |-> !config_clock && !$past(config_clock, 2);
    endproperty
    a_busy_after_fall: assert property (p_busy_after_fall) else $error("busy not fall timed");

    property p_prog_reset;
        $fell(program_n) |-> ##[1:4] !init_ready_n;
    endproperty
    a_prog_reset: assert property (p_prog_reset) else $error("program did not reset");
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for both ends of the byte configuration port
`timescale 1ns/1ns
`include "sbcp_defines.svh"
module tb_top;
    // ============================================================
    // Bench signals
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic start = 1'b0;
    logic [7:0] byte_src = 8'h00;
    logic byte_valid = 1'b0;
    logic byte_ready;
    logic [7:0] cfg_byte;
    logic cfg_valid;
    logic cfg_ready = 1'b0;
    logic done;
    logic abort;
    logic [7:0] cfg_byte2;
    logic cfg_valid2;
    logic abort2;
    logic done2;
    logic loading;
    logic took = 1'b0;
    logic missed = 1'b0;
    int src_idx = 0;
    int gap_left = 2;
    int sink_idx = 0;
    int cnt2 = 0;
    logic [7:0] last2 = 8'h00;
    logic [7:0] wire_q[$];
    int bad_count = 0;
    int checks = 0;
    sbcp_if lnk();
    sbcp_if lnk2();

    // Clock
    always #(`SBCP_CLK_NS / 2) mclk_in = ~mclk_in;

    // ============================================================
    // Both ends face each other; a second device faces the bench
    sbcp_host sbcp_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(lnk),
        .start_in(start), .byte_in(byte_src), .byte_valid_in(byte_valid),
        .byte_ready_out(byte_ready), .loading_out(loading));
    sbcp_dev sbcp_dev_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(lnk),
        .cfg_byte_out(cfg_byte), .cfg_valid_out(cfg_valid), .cfg_ready_in(cfg_ready),
        .done_out(done), .abort_out(abort));
    sbcp_dev sbcp_dev_inst2 (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(lnk2),
        .cfg_byte_out(cfg_byte2), .cfg_valid_out(cfg_valid2), .cfg_ready_in(1'b1),
        .done_out(done2), .abort_out(abort2));
    sbcp_chk sbcp_chk_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .config_clock(lnk.config_clock), .select_n(lnk.select_n),
        .write_select_n(lnk.write_select_n), .data(lnk.data), .program_n(lnk.program_n),
        .init_ready_n(lnk.init_ready_n), .busy(lnk.busy), .busy_oe(lnk.busy_oe),
        .busy_line(lnk.busy_line));

    // ============================================================
    // Helpers
    function automatic logic [7:0] pat(input int k);
        pat = 8'(k * 37 + 17);
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int j = 0; j < 8; j++)
            rev8[j] = b[7 - j];
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic timed_out;
        bad_count++;
        close_out;
    endtask

    // One link byte from the bench; tog pulses write select high while clock is low
    task automatic lb(input logic [7:0] b, input logic sel_n, input logic wr_n, input logic tog);
        @(negedge mclk_in);
        lnk2.select_n = sel_n;
        lnk2.write_select_n = wr_n | tog;
        lnk2.data = sel_n ? ~lnk2.data : rev8(b);
        repeat (4) @(negedge mclk_in);
        lnk2.write_select_n = wr_n;
        repeat (4) @(negedge mclk_in);
        lnk2.config_clock = 1'b1;
        repeat (8) @(negedge mclk_in);
        lnk2.config_clock = 1'b0;
    endtask

    task automatic prog2;
        lnk2.select_n = 1'b1;
        lnk2.program_n = 1'b0;
        repeat (`SBCP_PROG_CYCLES) @(negedge mclk_in);
        lnk2.program_n = 1'b1;
    endtask

    task automatic wait_init2;
        for (int k = 0; k < 100 && lnk2.init_ready_n !== 1'b1; k++)
            @(negedge mclk_in);
        if (lnk2.init_ready_n !== 1'b1)
            timed_out;
    endtask

    // ============================================================
    // Byte source, sink and wire monitor
    always @(posedge mclk_in)
    begin
        took <= byte_ready & byte_valid;
        missed <= byte_ready & ~byte_valid;
    end

    // Next source byte, with two empty slots before byte five
    always @(negedge mclk_in)
    begin
        if (took)
            src_idx = src_idx + 1;
        if (missed)
            gap_left = gap_left - 1;
        byte_src = pat(src_idx);
        byte_valid = rst_n_in && src_idx < `SBCP_STREAM_BYTES && !(src_idx == 5 && gap_left > 0);
    end

    // Drained bytes keep stream order
    always @(posedge mclk_in)
        if (rst_n_in && cfg_valid && cfg_ready)
        begin
            chk_byte(cfg_byte, pat(sink_idx));
            sink_idx++;
        end

    // Bytes on the wire at each accepted rising link edge
    always @(posedge lnk.config_clock)
        if (lnk.init_ready_n === 1'b1 && lnk.select_n === 1'b0 && lnk.busy_line === 1'b0)
            wire_q.push_back(rev8(lnk.data));

    // Second device output count
    always @(posedge mclk_in)
        if (cfg_valid2)
        begin
            cnt2 = cnt2 + 1;
            last2 = cfg_byte2;
        end

    // ============================================================
    // Main sequence
    initial
    begin
        lnk2.config_clock = 1'b0;
        lnk2.select_n = 1'b1;
        lnk2.write_select_n = 1'b1;
        lnk2.data = 8'h00;
        lnk2.program_n = 1'b1;
        repeat (12) @(negedge mclk_in);
        rst_n_in = 1'b1;
        for (int k = 0; k < 100 && lnk.init_ready_n !== 1'b1; k++)
            @(negedge mclk_in);
        chk_bit(lnk.init_ready_n, 1'b1);
        @(negedge mclk_in);
        start = 1'b1;
        @(negedge mclk_in);
        start = 1'b0;
        for (int k = 0; k < 3000 && lnk.busy_line !== 1'b1; k++)
            @(negedge mclk_in);
        if (lnk.busy_line !== 1'b1)
            timed_out;
        repeat (64) @(negedge mclk_in);
        chk_byte(8'(wire_q.size()), 8'(`SBCP_FIFO_DEPTH));
        cfg_ready = 1'b1;
        for (int k = 0; k < 20000 && done !== 1'b1; k++)
            @(negedge mclk_in);
        if (done !== 1'b1)
            timed_out;
        repeat (32) @(negedge mclk_in);
        chk_byte(8'(sink_idx), 8'(`SBCP_STREAM_BYTES));
        chk_byte(8'(wire_q.size()), 8'(`SBCP_STREAM_BYTES));
        foreach (wire_q[k])
            chk_byte(wire_q[k], pat(k));
        chk_bit(abort, 1'b0);
        chk_bit(loading, 1'b1);
        prog2;
        chk_bit(lnk2.init_ready_n, 1'b0);
        lb(8'h3c, 1'b0, 1'b0, 1'b0);
        chk_byte(8'(cnt2), 8'h00);
        wait_init2;
        lb(8'ha5, 1'b0, 1'b0, 1'b0);
        chk_byte(8'(cnt2), 8'h01);
        chk_byte(last2, 8'ha5);
        lb(8'h5a, 1'b1, 1'b1, 1'b0);
        chk_byte(8'(cnt2), 8'h01);
        chk_bit(abort2, 1'b0);
        lb(8'hc3, 1'b0, 1'b0, 1'b1);
        chk_byte(8'(cnt2), 8'h02);
        chk_bit(abort2, 1'b0);
        lb(8'h77, 1'b0, 1'b1, 1'b0);
        chk_bit(abort2, 1'b1);
        chk_bit(done2, 1'b0);
        lb(8'h11, 1'b0, 1'b0, 1'b0);
        chk_byte(8'(cnt2), 8'h02);
        prog2;
        wait_init2;
        chk_bit(abort2, 1'b0);
        lb(8'h96, 1'b0, 1'b0, 1'b0);
        chk_byte(8'(cnt2), 8'h03);
        chk_byte(last2, 8'h96);
        close_out;
    end
endmodule
